// [design/rtc_pkg.sv]
// Purpose: Shared constants and types for the serial clock/calendar/RAM
// Assumes: Command, address and register layout of the serial clock part
// Notes: Offsets are register addresses inside each command space

package rtc_pkg;
	// Clock space addresses
	localparam logic [4:0] ADDR_SEC = 5'h00;
	localparam logic [4:0] ADDR_MIN = 5'h01;
	localparam logic [4:0] ADDR_HOUR = 5'h02;
	localparam logic [4:0] ADDR_DATE = 5'h03;
	localparam logic [4:0] ADDR_MONTH = 5'h04;
	localparam logic [4:0] ADDR_WDAY = 5'h05;
	localparam logic [4:0] ADDR_YEAR = 5'h06;
	localparam logic [4:0] ADDR_CTRL = 5'h07;
	localparam logic [4:0] ADDR_BURST = 5'h1f;
	localparam logic [4:0] CLK_LAST = 5'h07;
	localparam logic [4:0] RAM_LAST = 5'h17;
	localparam int RAM_DEPTH = 24;
	// Command byte fields
	localparam int CMD_VALID = 7;
	localparam int CMD_RAM = 6;
	localparam int CMD_READ = 0;
	// Register bit positions
	localparam int HALT_BIT = 7;
	localparam int HOUR12_BIT = 7;
	localparam int PM_BIT = 5;
	localparam int LOCK_BIT = 7;
	localparam int OUTSEL_LO = 5;
	// Reset values
	localparam logic [7:0] SEC_RST = 8'h80;
	localparam logic [7:0] MIN_RST = 8'h00;
	localparam logic [7:0] HOUR_RST = 8'h00;
	localparam logic [7:0] DATE_RST = 8'h01;
	localparam logic [7:0] MONTH_RST = 8'h01;
	localparam logic [7:0] WDAY_RST = 8'h01;
	localparam logic [7:0] YEAR_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'ha0;
	// Half period of ~2 kHz output is ratio / 2^12
	localparam int OUT_2K_SHIFT = 12;
	// Serial link states
	typedef enum logic [1:0] {
		LINK_CMD = 2'b00,
		LINK_WR = 2'b01,
		LINK_RD = 2'b11,
		LINK_IGNORE = 2'b10
	} link_state_t;
	// One buffered register write
	typedef struct packed {
		logic ram;
		logic [4:0] addr;
		logic [7:0] data;
	} wr_entry_t;
endpackage

// [design/serial_clock_calendar_ram.sv]
// Purpose: Serial-linked BCD clock/calendar with control register and RAM
// Assumes: Serial pins and crystal are asynchronous and much slower than clk
// Notes: Crystal must stay below about 2.5 MHz to be sampled at 10 MHz
// Function
// - Chip select low starts transfer; first eight shift cycles give command byte.
// - Command and write bits sampled on rising edge; read bits driven on falling.
// - Every serial byte moves least significant bit first.
// - Command with bit 7 low ignored, plus all cycles until reselect.
// - Bit 6 picks RAM or clock space, bits 1-5 address, bit 0 read.
// - Address 31 selects burst in the chosen space and stores nothing.
// - Chip select high ends any transfer; new command needed afterwards.
// - Data pin released whenever chip select is high.
// - Write data bytes captured over next eight rising edges; extras ignored.
// - Read bytes driven over eight falling edges; extra cycles retransmit.
// - Time registers at addresses 0-6, all in BCD.
// - Seconds bit 7 halts the one hertz tick; powers up set.
// - Hours bit 7 selects 12-hour; then bit 5 is PM, else tens.
// - Control register at address 7: lock, output select, crystal mode, prescale.
// - Crystal mode picks binary, microprocessor, baud or colour-burst family.
// - Prescale with crystal mode picks divider for an exact one hertz tick.
// - Output select: crystal, half, quarter, or about 2048 Hz.
// - Lock flag powers up set and blocks all register writes.
// - Writing control may clear the lock without altering other bits.
// - Clock burst moves addresses 0 to 7 in order.
// - RAM holds 24 bytes; RAM burst moves all 24 in order.
// - Date rolls at month length; February has 29 days every fourth year.
// - Crystal mode and prescale reset to zero, binary 8.388608 MHz.

`timescale 1ns/1ns
`default_nettype none

module serial_clock_calendar_ram
	import rtc_pkg::*;
#(
	parameter int BUF_DEPTH = 2,
	parameter int DIV_SHIFT = 0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Serial link pins
	input wire logic ce_b,
	input wire logic sclk,
	input wire logic io_in,
	output logic io_out,
	output logic io_oe,
	// Crystal and clock output
	input wire logic xtal_in,
	output logic buffered_clock_out
);
	localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
	localparam int CW = $clog2(BUF_DEPTH + 1);

	//------------------------------------------------------------
	// Input synchronisers
	//------------------------------------------------------------
	logic ce_m, ce_s, sclk_m, sclk_s, sclk_d, io_m, io_s, xt_m, xt_s, xt_d;
	logic sclk_rise, sclk_fall, xt_rise;

	// Two flops per pin, then a delay stage for edges
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ce_m <= 1'b1;
			ce_s <= 1'b1;
			sclk_m <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
			io_m <= 1'b0;
			io_s <= 1'b0;
			xt_m <= 1'b0;
			xt_s <= 1'b0;
			xt_d <= 1'b0;
		end else begin
			ce_m <= ce_b;
			ce_s <= ce_m;
			sclk_m <= sclk;
			sclk_s <= sclk_m;
			sclk_d <= sclk_s;
			io_m <= io_in;
			io_s <= io_m;
			xt_m <= xtal_in;
			xt_s <= xt_m;
			xt_d <= xt_s;
		end
	end
	assign sclk_rise = sclk_s & ~sclk_d;
	assign sclk_fall = ~sclk_s & sclk_d;
	assign xt_rise = xt_s & ~xt_d;

	//------------------------------------------------------------
	// Register storage declarations
	//------------------------------------------------------------
	logic [7:0] sec, min, hour, date, month, wday, year, ctrl;
	logic [7:0] ram [RAM_DEPTH];
	logic [7:0] rd_data;
	wr_entry_t wr_head, push_entry;
	logic push_valid, in_ready, out_valid, out_ready, wr_fire, push_fire;
	logic tick, tick_go;

	//------------------------------------------------------------
	// Serial link engine
	//------------------------------------------------------------
	link_state_t state;
	logic [2:0] bit_cnt;
	logic [6:0] sh;
	logic [7:0] next_byte;
	logic space_ram, burst, oe;
	logic [4:0] addr, last_addr;

	// Byte as it stands once this rise is shifted in, LSB first
	assign next_byte = {io_s, sh};
	assign last_addr = space_ram ? RAM_LAST : CLK_LAST;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state <= LINK_CMD;
			bit_cnt <= 3'h0;
			sh <= 7'h00;
			space_ram <= 1'b0;
			burst <= 1'b0;
			addr <= 5'h00;
			oe <= 1'b0;
			io_out <= 1'b0;
			push_valid <= 1'b0;
			push_entry <= '0;
		end else begin
			// Pending write survives deselect; it is already committed
			if (push_fire) begin
				push_valid <= 1'b0;
			end
			if (ce_s) begin
				state <= LINK_CMD;
				bit_cnt <= 3'h0;
				oe <= 1'b0;
			end else begin
				unique case (state)
					LINK_CMD: begin
						if (sclk_rise) begin
							sh <= next_byte[7:1];
							bit_cnt <= bit_cnt + 3'h1;
							if (bit_cnt == 3'h7) begin
								space_ram <= next_byte[CMD_RAM];
								burst <= (next_byte[5:1] == ADDR_BURST);
								addr <= (next_byte[5:1] == ADDR_BURST) ? 5'h00 : next_byte[5:1];
								if (!next_byte[CMD_VALID]) begin
									state <= LINK_IGNORE;
								end else if (next_byte[CMD_READ]) begin
									state <= LINK_RD;
								end else begin
									state <= LINK_WR;
								end
							end
						end
					end
					LINK_WR: begin
						if (sclk_rise) begin
							sh <= next_byte[7:1];
							bit_cnt <= bit_cnt + 3'h1;
							if (bit_cnt == 3'h7) begin
								push_valid <= 1'b1;
								push_entry <= '{ram: space_ram, addr: addr, data: next_byte};
								// Single byte or end of burst: rest is ignored
								if (!burst || addr == last_addr) begin
									state <= LINK_IGNORE;
								end else begin
									addr <= addr + 5'h01;
								end
							end
						end
					end
					LINK_RD: begin
						if (sclk_fall) begin
							io_out <= rd_data[bit_cnt];
							oe <= 1'b1;
							bit_cnt <= bit_cnt + 3'h1;
							// Wrap keeps retransmitting while selected
							if (bit_cnt == 3'h7 && burst) begin
								addr <= (addr == last_addr) ? 5'h00 : addr + 5'h01;
							end
						end
					end
					LINK_IGNORE: begin
					end
				endcase
			end
		end
	end
	// Release is combinational so the pin frees on the same cycle
	assign io_oe = oe & ~ce_s;

	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_data = 8'h00;
		if (space_ram) begin
			if (addr <= RAM_LAST) begin
				rd_data = ram[addr];
			end
		end else begin
			case (addr)
				ADDR_SEC: rd_data = sec;
				ADDR_MIN: rd_data = min;
				ADDR_HOUR: rd_data = hour;
				ADDR_DATE: rd_data = date;
				ADDR_MONTH: rd_data = month;
				ADDR_WDAY: rd_data = wday;
				ADDR_YEAR: rd_data = year;
				ADDR_CTRL: rd_data = ctrl;
				default: rd_data = 8'h00;
			endcase
		end
	end

	//------------------------------------------------------------
	// Two-entry write buffer
	//------------------------------------------------------------
	wr_entry_t buf_mem [BUF_DEPTH];
	logic [PW-1:0] wr_ptr, rd_ptr;
	logic [CW-1:0] buf_cnt;

	function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
		return (p == PW'(BUF_DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	assign in_ready = (buf_cnt != CW'(BUF_DEPTH));
	assign out_valid = (buf_cnt != '0);
	// Drain stalls on a tick so calendar update and write never collide
	assign out_ready = ~tick_go;
	assign push_fire = push_valid & in_ready;
	assign wr_fire = out_valid & out_ready;
	assign wr_head = buf_mem[rd_ptr];

	// Pointers and occupancy
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			buf_cnt <= '0;
		end else begin
			if (push_fire) begin
				wr_ptr <= ptr_next(wr_ptr);
			end
			if (wr_fire) begin
				rd_ptr <= ptr_next(rd_ptr);
			end
			if (push_fire && !wr_fire) begin
				buf_cnt <= buf_cnt + CW'(1);
			end else if (wr_fire && !push_fire) begin
				buf_cnt <= buf_cnt - CW'(1);
			end
		end
	end

	// Entry storage, data only
	always_ff @(posedge clk) begin
		if (push_fire) begin
			buf_mem[wr_ptr] <= push_entry;
		end
	end

	//------------------------------------------------------------
	// Scratchpad RAM
	//------------------------------------------------------------
	// Lock also guards RAM; address 31 and above 23 store nothing
	always_ff @(posedge clk) begin
		if (wr_fire && wr_head.ram && wr_head.addr <= RAM_LAST && !ctrl[LOCK_BIT]) begin
			ram[wr_head.addr] <= wr_head.data;
		end
	end

	//------------------------------------------------------------
	// Calendar arithmetic
	//------------------------------------------------------------
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	logic [7:0] sec_inc, min_inc, h12_inc, h24_inc, date_inc, month_inc, year_inc, wday_inc;
	logic [7:0] next_hour, last_day;
	logic day_end, leap;

	assign sec_inc = bcd_inc({1'b0, sec[6:0]});
	assign min_inc = bcd_inc(min);
	assign h12_inc = bcd_inc({3'b000, hour[4:0]});
	assign h24_inc = bcd_inc({2'b00, hour[5:0]});
	assign date_inc = bcd_inc({2'b00, date[5:0]});
	assign month_inc = bcd_inc(month);
	assign year_inc = bcd_inc(year);
	assign wday_inc = bcd_inc({1'b0, wday[6:0]});
	// Every fourth year: tens even with 0/4/8, tens odd with 2/6
	assign leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6) :
		(year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);

	// Last day of the current month in BCD
	always_comb begin
		unique case (month)
			8'h02: last_day = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
			default: last_day = 8'h31;
		endcase
	end

	// Hour step in either format; flags the day boundary
	always_comb begin
		next_hour = hour;
		day_end = 1'b0;
		if (hour[HOUR12_BIT]) begin
			if (hour[4:0] == 5'h11) begin
				next_hour = {hour[7:6], ~hour[PM_BIT], 5'h12};
				day_end = hour[PM_BIT];
			end else if (hour[4:0] == 5'h12) begin
				next_hour = {hour[7:5], 5'h01};
			end else begin
				next_hour = {hour[7:5], h12_inc[4:0]};
			end
		end else if (hour[5:0] == 6'h23) begin
			next_hour = {hour[7:6], 6'h00};
			day_end = 1'b1;
		end else begin
			next_hour = {hour[7:6], h24_inc[5:0]};
		end
	end

	//------------------------------------------------------------
	// Time and control registers
	//------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sec <= SEC_RST;
			min <= MIN_RST;
			hour <= HOUR_RST;
			date <= DATE_RST;
			month <= MONTH_RST;
			wday <= WDAY_RST;
			year <= YEAR_RST;
			ctrl <= CTRL_RST;
		end else if (wr_fire && !wr_head.ram) begin
			if (wr_head.addr == ADDR_CTRL) begin
				if (!ctrl[LOCK_BIT]) begin
					ctrl <= wr_head.data;
				end else if (!wr_head.data[LOCK_BIT]) begin
					ctrl[LOCK_BIT] <= 1'b0;
				end
			end else if (!ctrl[LOCK_BIT]) begin
				case (wr_head.addr)
					ADDR_SEC: sec <= wr_head.data;
					ADDR_MIN: min <= wr_head.data;
					ADDR_HOUR: hour <= wr_head.data;
					ADDR_DATE: date <= wr_head.data;
					ADDR_MONTH: month <= wr_head.data;
					ADDR_WDAY: wday <= wr_head.data;
					ADDR_YEAR: year <= wr_head.data;
					default: begin
					end
				endcase
			end
		end else if (tick_go) begin
			if (sec[6:0] != 7'h59) begin
				sec[6:0] <= sec_inc[6:0];
			end else begin
				sec[6:0] <= 7'h00;
				if (min != 8'h59) begin
					min <= min_inc;
				end else begin
					min <= 8'h00;
					hour <= next_hour;
					if (day_end) begin
						wday[6:0] <= (wday[6:0] == 7'h07) ? 7'h01 : wday_inc[6:0];
						if (date[5:0] != last_day[5:0]) begin
							date[5:0] <= date_inc[5:0];
						end else begin
							date[5:0] <= 6'h01;
							if (month != 8'h12) begin
								month <= month_inc;
							end else begin
								month <= 8'h01;
								year <= (year == 8'h99) ? 8'h00 : year_inc;
							end
						end
					end
				end
			end
		end
	end

	//------------------------------------------------------------
	// Crystal dividers
	//------------------------------------------------------------
	// Crystal edges per second for each mode and prescale code
	function automatic logic [23:0] div_ratio(input logic [4:0] sel);
		unique case (sel[4:3])
			2'b00: div_ratio = sel[2:1] == 2'h0 ? 24'h800000 : sel[2:1] == 2'h1 ? 24'h400000 :
				sel[2:1] == 2'h2 ? 24'h200000 : (sel[0] ? 24'h008000 : 24'h100000);
			2'b01: unique case (sel[2:0])
				3'h0: div_ratio = 24'h7a1200;
				3'h1: div_ratio = 24'h4c4b40;
				3'h2: div_ratio = 24'h3d0900;
				3'h3: div_ratio = 24'h2625a0;
				3'h4: div_ratio = 24'h1e8480;
				3'h5: div_ratio = 24'h1312d0;
				3'h6: div_ratio = 24'h0f4240;
				3'h7: div_ratio = 24'h007a12;
			endcase
			2'b10: div_ratio = sel[2:1] == 2'h0 ? 24'h708000 : sel[2:1] == 2'h1 ? 24'h384000 :
				sel[2:1] == 2'h2 ? 24'h1c2000 : (sel[0] ? 24'h007080 : 24'h0e1000);
			2'b11: div_ratio = sel[2:1] == 2'h0 ? 24'h6d3d00 : sel[2:1] == 2'h1 ? 24'h369e80 :
				sel[2:1] == 2'h2 ? 24'h1b4f40 : (sel[0] ? 24'h006d3d : 24'h0da7a0);
		endcase
	endfunction

	logic [23:0] ratio, div_cnt;
	logic [11:0] k2_cnt, k2_half;
	logic [1:0] q_cnt;
	logic k2_clk;

	assign ratio = div_ratio(ctrl[4:0]) >> DIV_SHIFT;
	assign k2_half = (div_ratio(ctrl[4:0]) >> OUT_2K_SHIFT) == 24'h0 ? 12'h001 :
		12'(div_ratio(ctrl[4:0]) >> OUT_2K_SHIFT);
	assign tick_go = tick & ~sec[HALT_BIT];

	// One hertz tick; >= keeps a shrunk ratio from stalling
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			div_cnt <= 24'h0;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (xt_rise) begin
				if (div_cnt >= ratio - 24'h1) begin
					div_cnt <= 24'h0;
					tick <= 1'b1;
				end else begin
					div_cnt <= div_cnt + 24'h1;
				end
			end
		end
	end

	// Output divider chain and select
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q_cnt <= 2'h0;
			k2_cnt <= 12'h0;
			k2_clk <= 1'b0;
			buffered_clock_out <= 1'b0;
		end else begin
			if (xt_rise) begin
				q_cnt <= q_cnt + 2'h1;
				if (k2_cnt >= k2_half - 12'h1) begin
					k2_cnt <= 12'h0;
					k2_clk <= ~k2_clk;
				end else begin
					k2_cnt <= k2_cnt + 12'h1;
				end
			end
			unique case (ctrl[OUTSEL_LO+1:OUTSEL_LO])
				2'b00: buffered_clock_out <= xt_s;
				2'b01: buffered_clock_out <= q_cnt[0];
				2'b10: buffered_clock_out <= q_cnt[1];
				2'b11: buffered_clock_out <= k2_clk;
			endcase
		end
	end

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Pin free at once, and the drive flop cleared one cycle later
	property p_release;
		ce_s |-> !io_oe ##1 !oe;
	endproperty
	a_release: assert property (p_release) else $error("pin driven while deselected");

	property p_bad_cmd;
		state == LINK_CMD && !ce_s && sclk_rise && bit_cnt == 3'h7 && !io_s
			|=> state == LINK_IGNORE;
	endproperty
	a_bad_cmd: assert property (p_bad_cmd) else $error("invalid command accepted");

	property p_ignore_hold;
		state == LINK_IGNORE && !ce_s |=> state == LINK_IGNORE && !io_oe;
	endproperty
	a_ignore_hold: assert property (p_ignore_hold) else $error("left ignore early");

	property p_dir;
		state == LINK_CMD && !ce_s && sclk_rise && bit_cnt == 3'h7 && io_s
			|=> state == ($past(sh[0]) ? LINK_RD : LINK_WR) && space_ram == $past(sh[6]);
	endproperty
	a_dir: assert property (p_dir) else $error("command decode wrong");

	property p_burst;
		state == LINK_CMD && !ce_s && sclk_rise && bit_cnt == 3'h7 && sh[5:1] == 5'h1f
			|=> burst && addr == 5'h00;
	endproperty
	a_burst: assert property (p_burst) else $error("burst not started at zero");

	property p_drive;
		state == LINK_RD && !ce_s && sclk_fall |=> io_oe && io_out == $past(rd_data[bit_cnt]);
	endproperty
	a_drive: assert property (p_drive) else $error("read bit wrong");

	property p_capture;
		state == LINK_WR && !ce_s && sclk_rise && bit_cnt == 3'h7
			|=> push_valid && push_entry.data == $past(next_byte);
	endproperty
	a_capture: assert property (p_capture) else $error("write byte lost");

	property p_halt;
		sec[HALT_BIT] && !wr_fire |=> $stable(sec) && $stable(min);
	endproperty
	a_halt: assert property (p_halt) else $error("counted while halted");

	property p_lock;
		wr_fire && !wr_head.ram && ctrl[LOCK_BIT] |=> $stable(ctrl[6:0]) && $stable(hour);
	endproperty
	a_lock: assert property (p_lock) else $error("locked write took effect");

	property p_unlock;
		wr_fire && !wr_head.ram && wr_head.addr == ADDR_CTRL && !wr_head.data[LOCK_BIT]
			|=> !ctrl[LOCK_BIT];
	endproperty
	a_unlock: assert property (p_unlock) else $error("lock not cleared");

	property p_sec_wrap;
		tick_go && sec[6:0] == 7'h59 |=> sec[6:0] == 7'h00 && !$stable(min);
	endproperty
	a_sec_wrap: assert property (p_sec_wrap) else $error("no minute carry");

	c_burst_read: cover property (state == LINK_RD && burst && addr == last_addr && sclk_fall);
	c_unlock: cover property (wr_fire && wr_head.addr == ADDR_CTRL && !wr_head.ram);
	c_day_roll: cover property (tick_go && day_end && min == 8'h59 && sec[6:0] == 7'h59);
endmodule

`default_nettype wire

// [dv/serial_host_model.sv]
// Purpose: Host model driving the three-wire serial link
// Assumes: Pins change at clk falling edges, far slower than the synchronisers
// Notes: Phases of six clk each keep well clear of the four clk minimum

`timescale 1ns/1ns
`default_nettype none

module serial_host_model (
	// Clock
	input wire logic clk,
	// Serial pins
	output logic ce_b,
	output logic sclk,
	output logic host_oe,
	output logic host_d,
	input wire logic io_wire
);
	// Idle link: deselected, shift clock parked low
	initial begin
		ce_b = 1'b1;
		sclk = 1'b0;
		host_oe = 1'b0;
		host_d = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask

	// One cycle: data set while low, answer taken just before the fall
	task automatic shift(input logic d, input logic drv, output logic b);
		host_oe = drv;
		host_d = d;
		wait_clk(6);
		sclk = 1'b1;
		wait_clk(6);
		b = io_wire;
		sclk = 1'b0;
	endtask

	// Eight cycles make a byte, bit 0 first
	task automatic xfer_byte(input logic [7:0] d, input logic drv, output logic [7:0] q);
		logic b;
		for (int i = 0; i < 8; i++) begin
			shift(d[i], drv, b);
			q[i] = b;
		end
	endtask

	// Every frame opens fresh, so a command byte always comes first
	task automatic begin_frame();
		ce_b = 1'b0;
		wait_clk(4);
	endtask

	// Release the pin before deselecting; deselect long enough to be seen
	task automatic end_frame();
		host_oe = 1'b0;
		wait_clk(2);
		ce_b = 1'b1;
		wait_clk(24);
	endtask
endmodule

`default_nettype wire

// [dv/tb_serial_clock_calendar_ram.sv]
// Purpose: Self-checking bench for the serial clock/calendar/RAM
// Assumes: Host model paces the link; crystal at 1 MHz
// Notes: DIV_SHIFT of 10 with prescale 111 gives a tick every 32 crystal edges

`timescale 1ns/1ns
`default_nettype none

module tb_serial_clock_calendar_ram;
	import rtc_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic xtal_in = 1'b0;
	logic junk = 1'b0;
	logic io_out, io_oe, buffered_clock_out, ce_b, sclk, host_oe, host_d;
	wire logic io_wire;
	int n_errors = 0;
	int tests_run = 0;
	int xcnt = 0;
	int n_br = 0;
	logic [31:0] seed = 32'he938;
	logic [7:0] clk_m [0:7];
	logic [7:0] ram_m [0:23];
	logic [7:0] q [$];

	// Released pin shows the inverse of the last driven level
	assign io_wire = io_oe ? io_out : (host_oe ? host_d : junk);
	always #50 clk = ~clk;
	always @(negedge clk) begin
		if (io_oe || host_oe)
			junk <= ~io_wire;
	end
	// Output clock rises, counted for the divider checks
	always @(posedge buffered_clock_out) n_br++;
	// Crystal toggles every five clk, off the sampling edge
	always @(negedge clk) begin
		xcnt <= (xcnt == 4) ? 0 : xcnt + 1;
		xtal_in <= (xcnt == 4) ? ~xtal_in : xtal_in;
	end

	serial_clock_calendar_ram #(.BUF_DEPTH(2), .DIV_SHIFT(10)) serial_clock_calendar_ram_i (
		.clk(clk), .rst_b(rst_b), .ce_b(ce_b), .sclk(sclk), .io_in(io_wire),
		.io_out(io_out), .io_oe(io_oe), .xtal_in(xtal_in),
		.buffered_clock_out(buffered_clock_out));
	serial_host_model serial_host_model_i (.clk(clk), .ce_b(ce_b), .sclk(sclk),
		.host_oe(host_oe), .host_d(host_d), .io_wire(io_wire));

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Model write: lock guards everything, a locked control write only unlocks
	task automatic model_wr(input logic ram, input int a, input logic [7:0] d);
		if (clk_m[7][7]) begin
			if (!ram && a == 7 && !d[7])
				clk_m[7][7] = 1'b0;
		end else if (ram && a < 24)
			ram_m[a] = d;
		else if (!ram && a < 8)
			clk_m[a] = d;
	endtask

	// Write frame from q; a single write keeps only its first byte
	task automatic wr(input logic [7:0] cmd);
		logic [7:0] x;
		int a;
		a = cmd[5:1];
		serial_host_model_i.begin_frame();
		serial_host_model_i.xfer_byte(cmd, 1'b1, x);
		foreach (q[i]) begin
			serial_host_model_i.xfer_byte(q[i], 1'b1, x);
			if (cmd[7] && (a == 31 || i == 0))
				model_wr(cmd[6], (a == 31) ? i : a, q[i]);
		end
		serial_host_model_i.end_frame();
	endtask

	// Read frame of n bytes; bursts wrap, holes read zero
	task automatic rd(input logic [7:0] cmd, input int n);
		logic [7:0] x;
		int a;
		a = cmd[5:1];
		serial_host_model_i.begin_frame();
		serial_host_model_i.xfer_byte(cmd, 1'b1, x);
		for (int i = 0; i < n; i++) begin
			serial_host_model_i.xfer_byte(8'h00, 1'b0, x);
			if (cmd[6])
				chk(x, (a == 31) ? ram_m[i % 24] : ((a < 24) ? ram_m[a] : 8'h00));
			else
				chk(x, (a == 31) ? clk_m[i % 8] : ((a < 8) ? clk_m[a] : 8'h00));
		end
		serial_host_model_i.end_frame();
		chk({7'h00, io_oe}, 8'h00);
	endtask

	// Output clock rises over 40 crystal periods; phase does not matter
	task automatic chk_clk_out(input logic [7:0] exp);
		n_br = 0;
		repeat (400) @(negedge clk);
		chk(8'(n_br), exp);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog: the tests need about 16000 clk
	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		tally_and_finish();
	end

	initial begin
		clk_m = '{SEC_RST, MIN_RST, HOUR_RST, DATE_RST, MONTH_RST, WDAY_RST, YEAR_RST, CTRL_RST};
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		repeat (5) @(negedge clk);
		rd(8'hbf, 8);
		chk_clk_out(8'h14);
		$display("test 1 done");
		q = '{8'h12};
		wr(8'h80);
		q = '{8'h55};
		wr(8'hc0);
		rd(8'h81, 1);
		$display("test 2 done");
		q = '{8'h00};
		wr(8'h8e);
		rd(8'h8f, 1);
		q = '{8'h40};
		wr(8'h8e);
		chk_clk_out(8'h0a);
		q = '{8'h07, 8'h55};
		wr(8'h0e);
		rd(8'h8f, 1);
		$display("test 3 done");
		q.delete();
		repeat (24) q.push_back(rnd());
		wr(8'hfe);
		q = '{rnd()};
		wr(8'hee);
		rd(8'hff, 25);
		rd(8'hcb, 2);
		rd(8'h95, 1);
		$display("test 4 done");
		// Date and weekday bit 7 kept low by the host
		q = '{8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h07, 8'h01, 8'h07};
		wr(8'hbe);
		repeat (1000) @(negedge clk);
		q = '{8'h80, 8'h33};
		wr(8'h80);
		clk_m = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h03, 8'h01, 8'h01, 8'h07};
		rd(8'hbf, 8);
		@(negedge clk iff xcnt == 4);
		chk({7'h00, buffered_clock_out}, {7'h00, xtal_in});
		// Halted load first, so no tick can split the burst
		q = '{8'hd9, 8'h59, 8'hb1, 8'h28, 8'h02, 8'h03, 8'h04, 8'h07};
		wr(8'hbe);
		q = '{8'h59};
		wr(8'h80);
		repeat (1000) @(negedge clk);
		q = '{8'h80};
		wr(8'h80);
		// 11 PM rolls to 12 AM; leap year gives February 29
		clk_m = '{8'h80, 8'h00, 8'h92, 8'h29, 8'h02, 8'h04, 8'h04, 8'h07};
		rd(8'hbf, 8);
		$display("test 5 done");
		tally_and_finish();
	end
endmodule

`default_nettype wire
